/* rtl/fsp_ctrl.sv */
// run-time self-programming controller: table access, address capture, unlock and timed
// erase or program of one flash row
// assumes the core holds table operations while stall_out is high and that the
// array model outside takes a one-cycle command pulse plus the latch contents
`include "fsp_params.svh"

module fsp_ctrl (
	input  wire logic                  clk_in,
	input  wire logic                  sys_rst_in,
	input  wire fsp_pkg::fsp_sfr_req_t sfr_req_in,
	output logic [15:0]                sfr_rdata_out,
	input  wire fsp_pkg::fsp_tbl_req_t tbl_req_in,
	output logic                       tbl_ack_out,
	output logic [15:0]                tbl_rdata_out,
	output logic [23:0]                pm_addr_out,
	input  wire logic [23:0]           pm_rdata_in,
	output fsp_pkg::fsp_array_cmd_t    array_cmd_out,
	output logic [4:0]                 latch_index_out,
	input  wire logic [4:0]            latch_rd_index_in,
	output logic [23:0]                latch_word_out,
	input  wire logic                  array_done_in,
	output logic                       stall_out,
	output logic                       done_flag_out
);
	import fsp_pkg::*;

	localparam int unsigned OP_CYCLES = `FSP_OP_CYCLES;

	logic [15:0]   ctl_reg;
	logic [15:0]   adr_low_reg;
	logic [7:0]    adr_up_reg;
	logic [7:0]    table_page_register_reg;
	logic          tbl_phase_reg;
	logic [15:0]   tbl_rdata_reg;
	logic [23:0]   pm_addr_reg;
	logic [16:0]   timer_reg;
	logic          done_reg;
	logic          cmd_go_reg;
	fsp_op_state_t op_reg;
	fsp_op_state_t op_next;

	// register-port decode
	wire sfr_access = sfr_req_in.wr_en || sfr_req_in.rd_en;
	wire wr_ctl     = sfr_req_in.wr_en && (sfr_req_in.addr == `FSP_ADDR_CONTROL);
	wire wr_adr_lo  = sfr_req_in.wr_en && (sfr_req_in.addr == `FSP_ADDR_ADR_LOW);
	wire wr_adr_up  = sfr_req_in.wr_en && (sfr_req_in.addr == `FSP_ADDR_ADR_UPPER);
	wire wr_key     = sfr_req_in.wr_en && (sfr_req_in.addr == `FSP_ADDR_KEY);
	wire wr_pag     = sfr_req_in.wr_en && (sfr_req_in.addr == `FSP_ADDR_TABLE_PAGE_REGISTER);
	wire [15:0] wdata = sfr_req_in.wdata;

	// table operation: two cycles, address phase then data phase
	wire        busy      = (op_reg != FSP_IDLE);
	wire        tbl_first = tbl_req_in.valid && !tbl_phase_reg && !busy;
	wire        tbl_last  = tbl_req_in.valid && tbl_phase_reg;
	wire [23:0] tbl_addr  = {table_page_register_reg, tbl_req_in.ea};
	wire        latch_wr  = tbl_last && tbl_req_in.write;
	wire [4:0]  latch_idx = tbl_req_in.ea[5:1];

	// start bit set by software, honoured only after a full unlock
	wire key_open;
	wire start_req = wr_ctl && wdata[`FSP_CTL_START_BIT];
	wire permit    = ctl_reg[`FSP_CTL_PERMIT_BIT];
	wire launch    = start_req && key_open && permit && !busy;
	wire op_erase  = ctl_reg[`FSP_CTL_OP_MSB:`FSP_CTL_OP_LSB] == `FSP_OP_ROW_ERASE;
	wire op_prog   = ctl_reg[`FSP_CTL_OP_MSB:`FSP_CTL_OP_LSB] == `FSP_OP_ROW_PROGRAM;
	wire op_legal  = op_erase || op_prog;
	wire timer_end = (timer_reg == 17'(OP_CYCLES - 1));

	fsp_unlock u_unlock (
		.clk_in        (clk_in),
		.sys_rst_in    (sys_rst_in),
		.any_access_in (sfr_access),
		.key_write_in  (wr_key),
		.key_data_in   (wdata[7:0]),
		.consume_in    (launch),
		.open_out      (key_open)
	);

	fsp_latches u_latches (
		.clk_in       (clk_in),
		.sys_rst_in   (sys_rst_in),
		.wr_in        (latch_wr),
		.high_in      (tbl_req_in.high),
		.byte_mode_in (tbl_req_in.byte_mode),
		.odd_byte_in  (tbl_req_in.ea[0]),
		.index_in     (latch_idx),
		.data_in      (tbl_req_in.wdata),
		.rd_index_in  (latch_rd_index_in),
		.rd_word_out  (latch_word_out)
	);

	// operation sequencer
	always_comb begin
		op_next = op_reg;
		case (op_reg)
			FSP_IDLE: begin
				if (launch && op_legal)
					op_next = FSP_BUSY;
			end
			FSP_BUSY: begin
				if (timer_end || array_done_in)
					op_next = FSP_DONE;
			end
			FSP_DONE: op_next = FSP_IDLE;
			default:  op_next = FSP_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			op_reg <= FSP_IDLE;
		else
			op_reg <= op_next;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			timer_reg <= 17'h00000;
		else if (op_reg == FSP_BUSY)
			timer_reg <= timer_reg + 17'h00001;
		else
			timer_reg <= 17'h00000;
	end

	// one command pulse per launch with a legal op: a single row, erase or program
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cmd_go_reg <= 1'b0;
		else
			cmd_go_reg <= launch && op_legal;
	end

	// control register; start bit only sets by software, clears in hardware
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			ctl_reg <= `FSP_CTL_RESET;
		else begin
			if (wr_ctl && !busy)
				ctl_reg <= (wdata & `FSP_CTL_WMASK) | (ctl_reg & 16'h2000);
			if (launch && op_legal)
				ctl_reg[`FSP_CTL_START_BIT] <= 1'b1;
			else if (op_reg == FSP_DONE)
				ctl_reg[`FSP_CTL_START_BIT] <= 1'b0;
		end
	end

	// address registers: table capture wins over a direct write in the same cycle
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			adr_low_reg <= 16'h0000;
			adr_up_reg  <= 8'h00;
		end else if (tbl_first) begin
			adr_low_reg <= tbl_addr[15:0];
			adr_up_reg  <= tbl_addr[23:16];
		end else if (!busy) begin
			if (wr_adr_lo)
				adr_low_reg <= wdata;
			if (wr_adr_up)
				adr_up_reg <= wdata[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			table_page_register_reg <= 8'h00;
		else if (wr_pag)
			table_page_register_reg <= wdata[7:0];
	end

	// table operation phase and read data
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tbl_phase_reg <= 1'b0;
			pm_addr_reg   <= 24'h000000;
		end else if (tbl_first) begin
			tbl_phase_reg <= 1'b1;
			pm_addr_reg   <= tbl_addr;
		end else if (tbl_last) begin
			tbl_phase_reg <= 1'b0;
		end
	end

	wire [7:0]  rd_byte_lo = tbl_req_in.ea[0] ? pm_rdata_in[15:8] : pm_rdata_in[7:0];
	wire [15:0] rd_high    = tbl_req_in.byte_mode && tbl_req_in.ea[0] ? 16'h0000 :
		{8'h00, pm_rdata_in[23:16]};
	wire [15:0] rd_low     = tbl_req_in.byte_mode ? {8'h00, rd_byte_lo} :
		pm_rdata_in[15:0];

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tbl_rdata_reg <= 16'h0000;
		else if (tbl_last && !tbl_req_in.write)
			tbl_rdata_reg <= tbl_req_in.high ? rd_high : rd_low;
	end

	// completion flag: set by hardware at the end of an operation, cleared only by reset
	wire done_clear = wr_ctl && !wdata[`FSP_CTL_ERROR_BIT - 1] && 1'b0;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			done_reg <= 1'b0;
		else if (op_reg == FSP_DONE)
			done_reg <= 1'b1;
		else if (done_clear)
			done_reg <= 1'b0;
	end

	// key register reads as zero: it is write-only
	always_comb begin
		case (sfr_req_in.addr)
			`FSP_ADDR_CONTROL:   sfr_rdata_out = ctl_reg;
			`FSP_ADDR_ADR_LOW:   sfr_rdata_out = adr_low_reg;
			`FSP_ADDR_ADR_UPPER: sfr_rdata_out = {8'h00, adr_up_reg};
			`FSP_ADDR_TABLE_PAGE_REGISTER:    sfr_rdata_out = {8'h00, table_page_register_reg};
			default:             sfr_rdata_out = 16'h0000;
		endcase
	end

	assign stall_out           = busy;
	assign tbl_ack_out         = tbl_last;
	assign tbl_rdata_out       = tbl_rdata_reg;
	assign pm_addr_out         = pm_addr_reg;
	assign latch_index_out     = latch_idx;
	assign array_cmd_out.go    = cmd_go_reg;
	assign array_cmd_out.erase = op_erase;
	// row select ignores the low six address bits: a row is 32 words
	assign array_cmd_out.addr  = {adr_up_reg, adr_low_reg[15:6], 6'h00};
	assign done_flag_out       = done_reg;

endmodule : fsp_ctrl

/* rtl/fsp_latches.sv */
// panel write latches, 32 words of 24 bits, filled by table writes
// assumes the controller hands it one write per cycle at most
`include "fsp_params.svh"
module fsp_latches (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        wr_in,
	input  wire logic        high_in,
	input  wire logic        byte_mode_in,
	input  wire logic        odd_byte_in,
	input  wire logic [4:0]  index_in,
	input  wire logic [15:0] data_in,
	input  wire logic [4:0]  rd_index_in,
	output logic [23:0]      rd_word_out
);
	logic [23:0] word_reg [`FSP_ROW_WORDS];

	genvar gi;
	generate
		for (gi = 0; gi < `FSP_ROW_WORDS; gi++) begin : g_word
			wire hit = wr_in && (index_in == 5'(gi));
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in)
					word_reg[gi] <= 24'hFFFFFF;
				else if (hit && high_in)
					word_reg[gi][23:16] <= data_in[7:0];
				else if (hit && byte_mode_in && odd_byte_in)
					word_reg[gi][15:8] <= data_in[7:0];
				else if (hit && byte_mode_in)
					word_reg[gi][7:0] <= data_in[7:0];
				else if (hit)
					word_reg[gi][15:0] <= data_in;
			end
		end
	endgenerate

	assign rd_word_out = word_reg[rd_index_in];

endmodule : fsp_latches

/* rtl/fsp_params.svh */
// offsets, field positions, reset values and timing counts of the self-program controller
// assumes a 25 MHz core clock and a 16-bit special-function register port
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

`define FSP_ADDR_CONTROL   16'h0760
`define FSP_ADDR_ADR_LOW   16'h0762
`define FSP_ADDR_ADR_UPPER 16'h0764
`define FSP_ADDR_KEY       16'h0766
`define FSP_ADDR_TABLE_PAGE_REGISTER    16'h0032

`define FSP_CTL_START_BIT  15
`define FSP_CTL_PERMIT_BIT 14
`define FSP_CTL_ERROR_BIT  13
`define FSP_CTL_OP_LSB     0
`define FSP_CTL_OP_MSB     6
`define FSP_CTL_WMASK      16'h407F
`define FSP_CTL_RESET      16'h0000

`define FSP_OP_ROW_ERASE   7'h41
`define FSP_OP_ROW_PROGRAM 7'h01

`define FSP_KEY_FIRST      8'h55
`define FSP_KEY_SECOND     8'hAA

`define FSP_ROW_WORDS      32
`define FSP_PANEL_ROWS     128

`define FSP_OP_TIME_US     2000
`define FSP_CLK_MHZ        25
`define FSP_OP_CYCLES      (`FSP_OP_TIME_US * `FSP_CLK_MHZ)

`endif

/* rtl/fsp_pkg.sv */
// types shared by the self-program controller files
// assumes fsp_params.svh supplies the numeric constants
package fsp_pkg;

	typedef struct packed {
		logic        wr_en;
		logic        rd_en;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        byte_mode;
	} fsp_sfr_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        high;
		logic        byte_mode;
		logic [15:0] ea;
		logic [15:0] wdata;
	} fsp_tbl_req_t;

	typedef struct packed {
		logic        go;
		logic        erase;
		logic [23:0] addr;
	} fsp_array_cmd_t;

	typedef enum logic [1:0] {
		FSP_KEY_IDLE,
		FSP_KEY_HALF,
		FSP_KEY_OPEN
	} fsp_key_state_t;

	typedef enum logic [1:0] {
		FSP_IDLE,
		FSP_BUSY,
		FSP_DONE
	} fsp_op_state_t;

endpackage : fsp_pkg

/* rtl/fsp_unlock.sv */
// two-value unlock sequencer for the start bit
// assumes one register-port access per cycle at most
`include "fsp_params.svh"
module fsp_unlock (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        any_access_in,
	input  wire logic        key_write_in,
	input  wire logic [7:0]  key_data_in,
	input  wire logic        consume_in,
	output logic             open_out
);
	import fsp_pkg::*;

	fsp_key_state_t state_reg;
	fsp_key_state_t state_next;

	wire first_ok  = key_write_in && (key_data_in == `FSP_KEY_FIRST);
	wire second_ok = key_write_in && (key_data_in == `FSP_KEY_SECOND);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FSP_KEY_IDLE: begin
				if (first_ok)
					state_next = FSP_KEY_HALF;
			end
			FSP_KEY_HALF: begin
				// a repeated first key keeps the sequence; any other access or value drops it
				if (second_ok)
					state_next = FSP_KEY_OPEN;
				else if (first_ok)
					state_next = FSP_KEY_HALF;
				else if (any_access_in)
					state_next = FSP_KEY_IDLE;
			end
			FSP_KEY_OPEN: begin
				// the next access after the second key either starts or cancels
				if (first_ok)
					state_next = FSP_KEY_HALF;
				else if (any_access_in || consume_in)
					state_next = FSP_KEY_IDLE;
			end
			default: state_next = FSP_KEY_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			state_reg <= FSP_KEY_IDLE;
		else
			state_reg <= state_next;
	end

	assign open_out = (state_reg == FSP_KEY_OPEN);

endmodule : fsp_unlock

/* verification/fsp_cpu_model.sv */
// core model: two-cycle table operations and a program memory image
// assumes the bench never issues a table operation while the core is stalled
module fsp_cpu_model (
	input  wire logic           clk_in,
	input  wire logic           ack_in,
	input  wire logic [15:0]    rdata_in,
	input  wire logic [23:0]    pm_addr_in,
	output fsp_pkg::fsp_tbl_req_t tbl_req_out,
	output logic [23:0]         pm_rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import fsp_pkg::*;
	logic                   bm = 1'b0; // byte mode for the coming operations
	initial tbl_req_out = '0;
	assign pm_rdata_out = {pm_addr_in[23:16] ^ pm_addr_in[7:0], ~pm_addr_in[15:0]};
	task automatic op(input logic w, h, input logic [15:0] ea, wd,
		output logic [23:0] a, output logic [15:0] r);
		@(posedge clk_in);
		tbl_req_out <= '{valid:1'b1, write:w, high:h, byte_mode:bm, ea:ea, wdata:wd};
		@(posedge clk_in);
		@(negedge clk_in);
		a = ack_in ? pm_addr_in : 'x;
		@(posedge clk_in);
		// released fields are scrambled so a stale value cannot pass
		tbl_req_out <= '{valid:1'b0, write:w, high:h, byte_mode:1'b0, ea:~ea, wdata:~wd};
		@(negedge clk_in);
		r = rdata_in;
	endtask : op
endmodule : fsp_cpu_model

/* verification/fsp_ctrl_asserts.sv */
// port checker for fsp_ctrl
// assumes one core clock and the async high reset of the controller
`include "fsp_params.svh"
module fsp_ctrl_asserts (
	input wire logic                    clk_in,
	input wire logic                    sys_rst_in,
	input wire fsp_pkg::fsp_sfr_req_t   sfr_req_in,
	input wire logic [15:0]             sfr_rdata_out,
	input wire fsp_pkg::fsp_tbl_req_t   tbl_req_in,
	input wire logic                    tbl_ack_out,
	input wire logic [15:0]             tbl_rdata_out,
	input wire logic [23:0]             pm_addr_out,
	input wire logic [23:0]             pm_rdata_in,
	input wire fsp_pkg::fsp_array_cmd_t array_cmd_out,
	input wire logic [4:0]              latch_index_out,
	input wire logic                    stall_out,
	input wire logic                    done_flag_out
);
	import fsp_pkg::*;
	localparam int MAX_STALL = 50001;
	int          stall_cnt;
	logic [23:0] pm_q;
	logic        ctl_ok;
	wire wr_key = sfr_req_in.wr_en && sfr_req_in.addr == `FSP_ADDR_KEY;
	wire wr_ctl = sfr_req_in.wr_en && sfr_req_in.addr == `FSP_ADDR_CONTROL;
	wire rd_ctl = sfr_req_in.rd_en && sfr_req_in.addr == `FSP_ADDR_CONTROL;
	wire key_two = wr_key && sfr_req_in.wdata[7:0] == `FSP_KEY_SECOND;
	wire rd_op = tbl_ack_out && !tbl_req_in.write;
	// both legal ops share bits 5..0, so permit plus 01 there is enough
	wire op_ok = sfr_req_in.wdata[14] && sfr_req_in.wdata[5:0] == 6'h01;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stall_cnt <= 0;
			pm_q      <= '0;
			ctl_ok    <= 1'b0;
		end else begin
			stall_cnt <= stall_out ? stall_cnt + 1 : 0;
			pm_q      <= pm_rdata_in;
			if (wr_ctl && !stall_out)
				ctl_ok <= op_ok;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_key_first;
		wr_key && sfr_req_in.wdata[7:0] == `FSP_KEY_FIRST && !stall_out;
	endsequence
	sequence s_unlock_start;
		s_key_first ##1 key_two ##1 wr_ctl && sfr_req_in.wdata[15] && ctl_ok && !stall_out;
	endsequence
	chk_stall_bound: assert property (stall_cnt <= MAX_STALL)
		else $error("stall lasted too long");
	chk_unlock_start: assert property (s_unlock_start |=> stall_out && array_cmd_out.go)
		else $error("unlocked start did not launch");
	chk_key_cancel: assert property (s_key_first ##1 !key_two |=> !stall_out [*2])
		else $error("broken key still launched");
	chk_go_pulse: assert property (array_cmd_out.go |=> !array_cmd_out.go)
		else $error("array command longer than one cycle");
	chk_ack_shape: assert property (tbl_ack_out
		|-> $past(tbl_req_in.valid) && !array_cmd_out.go)
		else $error("table ack without held request or with array command");
	chk_addr_form: assert property (tbl_ack_out |-> pm_addr_out[15:0] == tbl_req_in.ea
		&& latch_index_out == tbl_req_in.ea[5:1])
		else $error("table address not formed from ea");
	chk_read_low: assert property (rd_op && !tbl_req_in.high && !tbl_req_in.byte_mode
		|=> tbl_rdata_out == pm_q[15:0])
		else $error("low table read wrong");
	chk_read_high: assert property (rd_op && tbl_req_in.high
		|=> tbl_rdata_out[7:0] == pm_q[23:16])
		else $error("high table read wrong");
	chk_done_flag: assert property ($fell(stall_out) |-> ##[0:1] done_flag_out)
		else $error("done flag not set at finish");
	chk_start_bit: assert property (stall_out && rd_ctl |-> sfr_rdata_out[15])
		else $error("start bit low while busy");
endmodule : fsp_ctrl_asserts

bind fsp_ctrl fsp_ctrl_asserts u_chk (.clk_in, .sys_rst_in, .sfr_req_in, .sfr_rdata_out,
	.tbl_req_in, .tbl_ack_out, .tbl_rdata_out, .pm_addr_out, .pm_rdata_in, .array_cmd_out,
	.latch_index_out, .stall_out, .done_flag_out);

/* verification/fsp_ctrl_tb.sv */
// self-checking bench for fsp_ctrl: table access, unlock, erase, program
// assumes fsp_cpu_model as core side and fsp_ctrl_asserts bound in
`include "fsp_params.svh"
module fsp_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fsp_pkg::*;
	typedef struct packed {
		logic        wr;
		logic        hi;
		logic [15:0] ea;
		logic [15:0] wd;
		logic [23:0] exp;
	} fsp_row_t;
	logic           clk_in = 1'b0;
	logic           sys_rst_in = 1'b1;
	logic           array_done_in = 1'b0;
	logic [4:0]     latch_rd_index_in = 5'h00;
	fsp_sfr_req_t   sfr_req_in = '0;
	fsp_tbl_req_t   tbl_req_in;
	fsp_array_cmd_t array_cmd_out;
	logic [15:0]    sfr_rdata_out, tbl_rdata_out, rd;
	logic [23:0]    pm_addr_out, pm_rdata_in, latch_word_out, ack_addr;
	logic [4:0]     latch_index_out;
	logic           tbl_ack_out, stall_out, done_flag_out;
	int             err_total = 0;
	int             checks_done = 0;
	int             cyc = 0;
	int             n;
	wire [23:0]     cmd_view = {21'h0, stall_out, array_cmd_out.go, array_cmd_out.erase};
	// one aligned block in one panel, words ascending from zero
	fsp_row_t rows [7] = '{
		'{1'b0, 1'b0, 16'h6000, 16'h0000, 24'h009FFF},
		'{1'b0, 1'b1, 16'h6000, 16'h0000, 24'h00003A},
		'{1'b1, 1'b0, 16'h6000, 16'h1234, 24'hFF1234},
		'{1'b1, 1'b1, 16'h6000, 16'hBE12, 24'h121234},
		'{1'b1, 1'b0, 16'h6002, 16'hABCD, 24'hFFABCD},
		'{1'b1, 1'b1, 16'h6002, 16'hFF56, 24'h56ABCD},
		'{1'b0, 1'b1, 16'h603E, 16'h0000, 24'h000004}};
	fsp_ctrl dut (.clk_in, .sys_rst_in, .sfr_req_in, .sfr_rdata_out, .tbl_req_in,
		.tbl_ack_out, .tbl_rdata_out, .pm_addr_out, .pm_rdata_in, .array_cmd_out,
		.latch_index_out, .latch_rd_index_in, .latch_word_out, .array_done_in,
		.stall_out, .done_flag_out);
	fsp_cpu_model u_cpu (.clk_in(clk_in), .ack_in(tbl_ack_out), .rdata_in(tbl_rdata_out),
		.pm_addr_in(pm_addr_out), .tbl_req_out(tbl_req_in), .pm_rdata_out(pm_rdata_in));
	always #20 clk_in = ~clk_in;
	task automatic chk(input logic [23:0] e, g, input string m);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic sfr_wr(input logic [15:0] a, d);
		@(posedge clk_in);
		sfr_req_in <= '{wr_en:1'b1, rd_en:1'b0, addr:a, wdata:d, byte_mode:1'b0};
	endtask : sfr_wr
	task automatic sfr_rd(input logic [15:0] a);
		@(posedge clk_in);
		sfr_req_in <= '{wr_en:1'b0, rd_en:1'b1, addr:a, wdata:16'h0000, byte_mode:1'b0};
		@(negedge clk_in);
		rd = sfr_rdata_out;
	endtask : sfr_rd
	task automatic sfr_idle;
		@(posedge clk_in);
		sfr_req_in <= '0;
		@(negedge clk_in);
	endtask : sfr_idle
	task automatic unlock(input logic [7:0] k2, input logic [15:0] ctl);
		sfr_wr(`FSP_ADDR_KEY, 16'h0055);
		sfr_wr(`FSP_ADDR_KEY, {8'h00, k2});
		sfr_wr(`FSP_ADDR_CONTROL, ctl);
		sfr_idle();
	endtask : unlock
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		// one full erase of 50000 cycles plus 2000 cycles for setup and the program run
		if (cyc == 52000) begin
			err_total++;
			$display("mismatch at %0t: run did not finish", $time);
			summarize();
		end
	end
	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		sfr_rd(`FSP_ADDR_CONTROL);
		chk({8'h00, `FSP_CTL_RESET}, {8'h00, rd}, "control reset");
		chk(24'hFFFFFF, latch_word_out, "latch reset");
		sfr_wr(`FSP_ADDR_TABLE_PAGE_REGISTER, 16'h013A);
		foreach (rows[i]) begin
			@(posedge clk_in);
			latch_rd_index_in <= rows[i].ea[5:1];
			u_cpu.op(rows[i].wr, rows[i].hi, rows[i].ea, rows[i].wd, ack_addr, rd);
			chk({8'h3A, rows[i].ea}, ack_addr, "table address");
			if (rows[i].wr)
				chk(rows[i].exp, latch_word_out, "latch");
			else
				chk(rows[i].exp, rows[i].hi ? {16'h0, rd[7:0]} : {8'h00, rd}, "read");
			sfr_rd(`FSP_ADDR_ADR_LOW);
			chk({8'h00, rows[i].ea}, {8'h00, rd}, "address low");
			sfr_rd(`FSP_ADDR_ADR_UPPER);
			chk(24'h00003A, {8'h00, rd}, "address upper");
			sfr_idle();
		end
		// byte mode: odd low byte lands in bits 15..8, odd read returns bits 15..8
		@(posedge clk_in);
		latch_rd_index_in <= 5'h01;
		u_cpu.bm = 1'b1;
		u_cpu.op(1'b1, 1'b0, 16'h6003, 16'h0077, ack_addr, rd);
		chk(24'h5677CD, latch_word_out, "byte write");
		u_cpu.op(1'b0, 1'b0, 16'h6001, 16'h0000, ack_addr, rd);
		chk(24'h00009F, {8'h00, rd}, "byte read");
		u_cpu.bm = 1'b0;
		sfr_wr(`FSP_ADDR_CONTROL, 16'hFFFF);
		sfr_rd(`FSP_ADDR_CONTROL);
		chk({8'h00, `FSP_CTL_WMASK}, {8'h00, rd}, "control fields");
		sfr_wr(`FSP_ADDR_CONTROL, 16'h4041);
		sfr_wr(`FSP_ADDR_ADR_LOW, 16'h1240);
		sfr_wr(`FSP_ADDR_ADR_UPPER, 16'h0021);
		sfr_rd(`FSP_ADDR_KEY);
		chk(24'h000000, {8'h00, rd}, "key read");
		sfr_wr(`FSP_ADDR_KEY, 16'h0055);
		sfr_rd(`FSP_ADDR_CONTROL);
		unlock(8'h5A, 16'hC041);
		chk(24'h000000, {23'h0, stall_out}, "refused start");
		unlock(8'hAA, 16'hC041);
		chk(24'h211240, array_cmd_out.addr, "erase row");
		chk(24'h000007, cmd_view, "erase go");
		sfr_rd(`FSP_ADDR_CONTROL);
		chk(24'h000001, {23'h0, rd[15]}, "start bit busy");
		sfr_idle();
		// core waits out the stall, as two no-operations would
		for (n = 2; n < 60000 && stall_out === 1'b1; n++)
			@(negedge clk_in);
		chk(24'd50001, n[23:0], "stall length");
		chk(24'h000001, {23'h0, done_flag_out}, "done flag");
		sfr_rd(`FSP_ADDR_CONTROL);
		chk(24'h000000, {23'h0, rd[15]}, "start bit cleared");
		sfr_wr(`FSP_ADDR_CONTROL, 16'h4001);
		unlock(8'hAA, 16'hC001);
		chk(24'h000006, cmd_view, "program go");
		repeat (10) @(posedge clk_in);
		array_done_in <= 1'b1;
		@(posedge clk_in);
		array_done_in <= 1'b0;
		for (n = 0; n < 8 && stall_out !== 1'b0; n++)
			@(negedge clk_in);
		chk(24'h000000, {23'h0, stall_out}, "early finish");
		summarize();
	end
endmodule : fsp_ctrl_tb
